/* hw/wsc_defines.vh */
// Offsets, field positions, reset values and timing counts of the wake source control block
`ifndef WSC_DEFINES_VH
`define WSC_DEFINES_VH

// Register addresses (7-bit serial interface address space)
`define WSC_ADDR_W 7
`define WSC_ADDR_SRC 7'h07
`define WSC_ADDR_PULL 7'h08
`define WSC_ADDR_FLT 7'h09

// Wake source register field positions
`define WSC_SRC_INT_SCOPE 7
`define WSC_SRC_MEAS_SEL 5
`define WSC_SRC_EN_C 2
`define WSC_SRC_EN_B 1
`define WSC_SRC_EN_A 0

// Writable masks; everything else is reserved and reads zero
`define WSC_SRC_WMASK 8'hA7
`define WSC_CFG_WMASK 8'h3F

// Reset values after power-on or soft reset
`define WSC_SRC_RESET 8'h07
`define WSC_CFG_RESET 8'h00

// Restart: bits kept from the old value (pattern x0x0 0xxx and 00xx xxxx)
`define WSC_SRC_RESTART_KEEP 8'hA7
`define WSC_CFG_RESTART_KEEP 8'h3F

// Fail-safe entry: wake source register becomes x0x0 0111
`define WSC_SRC_FS_KEEP 8'hA0
`define WSC_SRC_FS_SET 8'h07

// Fail-safe values for the two bus control registers held elsewhere
`define WSC_BUS1_FS_KEEP 8'hE0
`define WSC_BUS1_FS_SET 8'h09
`define WSC_BUS2_FS_VALUE 8'h01

// Pull field codes
`define WSC_PULL_NONE 2'h0
`define WSC_PULL_DOWN 2'h1
`define WSC_PULL_UP 2'h2
`define WSC_PULL_AUTO 2'h3

// Filter field codes
`define WSC_FLT_STATIC_SHORT 2'h0
`define WSC_FLT_STATIC_LONG 2'h1
`define WSC_FLT_CYCLIC_T1 2'h2
`define WSC_FLT_CYCLIC_T2 2'h3

// Timing: clock period and filter times in ns, counts rounded up
`define WSC_CLK_PERIOD_NS 40
`define WSC_FILT_SHORT_NS 16000
`define WSC_FILT_LONG_NS 64000
`define WSC_FILT_SHORT_CYC ((`WSC_FILT_SHORT_NS + `WSC_CLK_PERIOD_NS - 1) / `WSC_CLK_PERIOD_NS)
`define WSC_FILT_LONG_CYC ((`WSC_FILT_LONG_NS + `WSC_CLK_PERIOD_NS - 1) / `WSC_CLK_PERIOD_NS)
`define WSC_CNT_W 11

`endif

/* hw/wsc_filter.v */
// Debounce filter for one wake input: static or cyclic sensing
`timescale 1ns/1ps
`include "wsc_defines.vh"

module wsc_filter #(
  parameter SHORT_CYC = `WSC_FILT_SHORT_CYC,
  parameter LONG_CYC = `WSC_FILT_LONG_CYC
) (
  // Clock, reset, enable
  input wire i_clock,
  input wire i_rst,
  input wire i_clk_en,
  // Synchronised pin level and configuration
  input wire i_level,
  input wire [1:0] i_mode,
  input wire i_timer1_on_end,
  input wire i_timer2_on_end,
  // Filtered level and one-cycle change pulse
  output reg o_level_ff,
  output reg o_change_ff
);

  // Last count of each filter, cut to the counter width on purpose
  localparam integer SHORT_LAST_INT = SHORT_CYC - 1;
  localparam integer LONG_LAST_INT = LONG_CYC - 1;
  localparam [`WSC_CNT_W-1:0] SHORT_LAST = SHORT_LAST_INT[`WSC_CNT_W-1:0];
  localparam [`WSC_CNT_W-1:0] LONG_LAST = LONG_LAST_INT[`WSC_CNT_W-1:0];
  localparam [`WSC_CNT_W-1:0] CNT_ONE = {{(`WSC_CNT_W-1){1'b0}}, 1'b1};

  reg [`WSC_CNT_W-1:0] stable_cnt_ff; // Cycles the pin has differed from the accepted level
  reg [`WSC_CNT_W-1:0] nxt_stable_cnt;
  reg nxt_level;
  reg nxt_change;
  reg cyclic; // Cyclic modes judge the pin only at a timer on-time end
  reg sample_strobe;
  reg [`WSC_CNT_W-1:0] last;

  // Next-state logic: a change is accepted only after the full filter time
  always @* begin
    nxt_stable_cnt = stable_cnt_ff;
    nxt_level = o_level_ff;
    nxt_change = 1'b0;
    cyclic = i_mode[1];
    sample_strobe = (i_mode == `WSC_FLT_CYCLIC_T1) ? i_timer1_on_end : i_timer2_on_end;
    last = (i_mode == `WSC_FLT_STATIC_LONG) ? LONG_LAST : SHORT_LAST;
    if (i_level == o_level_ff) begin
      // A pulse shorter than the filter time is dropped here
      nxt_stable_cnt = {`WSC_CNT_W{1'b0}};
    end else if (stable_cnt_ff < last) begin
      nxt_stable_cnt = stable_cnt_ff + CNT_ONE;
    end
    if (i_level != o_level_ff && stable_cnt_ff >= last) begin
      if (!cyclic || sample_strobe) begin
        // Static accepts at once; cyclic waits for the on-time end
        nxt_level = i_level;
        nxt_change = 1'b1;
        nxt_stable_cnt = {`WSC_CNT_W{1'b0}};
      end
    end
  end

  // State registers, frozen while the clock enable is low
  always @(posedge i_clock) begin
    if (i_rst) begin
      stable_cnt_ff <= {`WSC_CNT_W{1'b0}};
      o_level_ff <= 1'b0;
      o_change_ff <= 1'b0;
    end else if (i_clk_en) begin
      stable_cnt_ff <= nxt_stable_cnt;
      o_level_ff <= nxt_level;
      o_change_ff <= nxt_change;
    end
  end

endmodule

/* hw/wsc_top.v */
// Wake source control: three wake configuration registers, input filters and wake detection
// What this block does
// - Scope bit: wake-only or all status interrupt
// - Measure select disables wake on inputs a,b
// - Measure select enables measurement in Normal Mode
// - Enable bits make each input wake source
// - Fail-safe entry forces wakeable register values
// - Source register reset and restart values
// - Pull and filter reset, restart values
// - Pull field: none, down, up, auto
// - Static filters of 16 or 64 us
// - Cyclic sensing at timer on-time end
// - Reserved bits always read zero
`timescale 1ns/1ps
`include "wsc_defines.vh"

module wsc_top #(
  parameter SHORT_CYC = `WSC_FILT_SHORT_CYC,
  parameter LONG_CYC = `WSC_FILT_LONG_CYC
) (
  // Clock, reset, enable
  input wire i_clock,
  input wire i_rst,
  input wire i_clk_en,
  // Register port from the serial interface frame decoder
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [`WSC_ADDR_W-1:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata_ff,
  // Mode and reset causes from the chip state machine
  input wire i_normal_mode,
  input wire i_restart,
  input wire i_fail_safe_entry,
  input wire i_status_event,
  // Timer on-time end pulses for cyclic sensing
  input wire i_timer1_on_end,
  input wire i_timer2_on_end,
  // Wake input pins (asynchronous)
  input wire [2:0] i_wake_pin,
  // Pull controls per input
  output reg [2:0] o_pull_up_ff,
  output reg [2:0] o_pull_down_ff,
  output reg [2:0] o_pull_auto_ff,
  // Wake results
  output reg [2:0] o_wake_level_ff,
  output reg [2:0] o_wake_event_ff,
  output reg o_int_ff,
  output reg o_meas_en_ff,
  // Fail-safe load for the bus control registers
  output reg o_bus_fs_load_ff
);

  reg [7:0] src_ff; // Wake source enable register
  reg [7:0] pull_ff; // Wake pull configuration register
  reg [7:0] flt_ff; // Wake filter configuration register
  reg [7:0] nxt_src;
  reg [7:0] nxt_pull;
  reg [7:0] nxt_flt;
  reg [7:0] nxt_rdata;
  reg [2:0] sync1_ff; // First synchroniser stage, read only by stage two
  reg [2:0] sync2_ff;
  reg [2:0] sync3_ff;
  reg [2:0] pin_level_ff; // Level accepted once stages two and three agree
  reg [2:0] nxt_pin_level;
  wire [2:0] filt_level;
  wire [2:0] filt_change;
  reg [2:0] wake_en; // Effective wake enables after measurement override
  reg [2:0] nxt_event;
  reg [2:0] nxt_pu;
  reg [2:0] nxt_pd;
  reg [2:0] nxt_pa;
  integer k; // Loop index of the synchroniser
  integer j; // Loop index of the pull decode

  // Decode a 2-bit pull code into up, down and auto enables
  function [2:0] pull_decode;
    input [1:0] code;
    begin
      case (code)
        `WSC_PULL_NONE: pull_decode = 3'h0;
        `WSC_PULL_DOWN: pull_decode = 3'h2;
        `WSC_PULL_UP: pull_decode = 3'h4;
        `WSC_PULL_AUTO: pull_decode = 3'h1;
        default: pull_decode = 3'h0;
      endcase
    end
  endfunction

  // Register update; reset beats fail-safe, fail-safe beats restart, restart beats a write
  always @* begin
    nxt_src = src_ff;
    nxt_pull = pull_ff;
    nxt_flt = flt_ff;
    if (i_fail_safe_entry) begin
      // Keep the chip wakeable: all three enable bits are set, but a kept measure select still masks inputs a and b
      nxt_src = (src_ff & `WSC_SRC_FS_KEEP) | `WSC_SRC_FS_SET;
    end else if (i_restart) begin
      nxt_src = src_ff & `WSC_SRC_RESTART_KEEP;
      nxt_pull = pull_ff & `WSC_CFG_RESTART_KEEP;
      nxt_flt = flt_ff & `WSC_CFG_RESTART_KEEP;
    end else if (i_reg_wr) begin
      // Reserved bits are masked on write so they can never read back set
      case (i_reg_addr)
        `WSC_ADDR_SRC: nxt_src = i_reg_wdata & `WSC_SRC_WMASK;
        `WSC_ADDR_PULL: nxt_pull = i_reg_wdata & `WSC_CFG_WMASK;
        `WSC_ADDR_FLT: nxt_flt = i_reg_wdata & `WSC_CFG_WMASK;
        default: nxt_src = src_ff;
      endcase
    end
  end

  // Read mux; unmapped addresses answer zero
  always @* begin
    case (i_reg_addr)
      `WSC_ADDR_SRC: nxt_rdata = src_ff;
      `WSC_ADDR_PULL: nxt_rdata = pull_ff;
      `WSC_ADDR_FLT: nxt_rdata = flt_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Configuration registers and read data
  always @(posedge i_clock) begin
    if (i_rst) begin
      src_ff <= `WSC_SRC_RESET;
      pull_ff <= `WSC_CFG_RESET;
      flt_ff <= `WSC_CFG_RESET;
      o_reg_rdata_ff <= 8'h00;
      o_bus_fs_load_ff <= 1'b0;
    end else if (i_clk_en) begin
      src_ff <= nxt_src;
      pull_ff <= nxt_pull;
      flt_ff <= nxt_flt;
      if (i_reg_rd) begin
        o_reg_rdata_ff <= nxt_rdata;
      end
      // Tells the bus control block to load its fail-safe wake values
      o_bus_fs_load_ff <= i_fail_safe_entry;
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      nxt_pin_level[k] = (sync2_ff[k] == sync3_ff[k]) ? sync3_ff[k] : pin_level_ff[k];
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
      pin_level_ff <= 3'h0;
    end else if (i_clk_en) begin
      sync1_ff <= i_wake_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_level_ff <= nxt_pin_level;
    end
  end

  // One filter per wake input; filter code sits at bits 2i+1:2i
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
      wsc_filter #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
      ) u_filter (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_level(pin_level_ff[gi]),
        .i_mode(flt_ff[2*gi+1:2*gi]),
        .i_timer1_on_end(i_timer1_on_end),
        .i_timer2_on_end(i_timer2_on_end),
        .o_level_ff(filt_level[gi]),
        .o_change_ff(filt_change[gi])
      );
    end
  endgenerate

  // Effective enables, wake events and pull decode
  always @* begin
    wake_en[2] = src_ff[`WSC_SRC_EN_C];
    // Measurement select overrides the enables of inputs a and b
    wake_en[1] = src_ff[`WSC_SRC_EN_B] & ~src_ff[`WSC_SRC_MEAS_SEL];
    wake_en[0] = src_ff[`WSC_SRC_EN_A] & ~src_ff[`WSC_SRC_MEAS_SEL];
    nxt_event = filt_change & wake_en;
    for (j = 0; j < 3; j = j + 1) begin
      {nxt_pu[j], nxt_pd[j], nxt_pa[j]} = pull_decode(pull_ff[2*j+1 -: 2]);
    end
  end

  // Output registers
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_pull_up_ff <= 3'h0;
      o_pull_down_ff <= 3'h0;
      o_pull_auto_ff <= 3'h0;
      o_wake_level_ff <= 3'h0;
      o_wake_event_ff <= 3'h0;
      o_int_ff <= 1'b0;
      o_meas_en_ff <= 1'b0;
    end else if (i_clk_en) begin
      o_pull_up_ff <= nxt_pu;
      o_pull_down_ff <= nxt_pd;
      o_pull_auto_ff <= nxt_pa;
      // Level of inputs a and b is meaningless to software while measuring
      o_wake_level_ff <= filt_level;
      o_wake_event_ff <= nxt_event;
      // Scope bit widens the interrupt to all other status events
      o_int_ff <= (|nxt_event) | (src_ff[`WSC_SRC_INT_SCOPE] & i_status_event);
      o_meas_en_ff <= src_ff[`WSC_SRC_MEAS_SEL] & i_normal_mode;
    end
  end

endmodule

/* bench/wsc_top_asserts.sv */
// Concurrent checks on the wake source control ports
`timescale 1ns/1ps
`include "wsc_defines.vh"
module wsc_top_asserts #(
  parameter SHORT_CYC = 8,
  parameter LONG_CYC = 20
) (
  // Clock, reset and register strobes
  input wire i_clock,
  input wire i_rst,
  input wire i_clk_en,
  input wire i_reg_rd,
  input wire [6:0] i_reg_addr,
  // Chip state inputs and pins
  input wire i_normal_mode,
  input wire i_fail_safe_entry,
  input wire i_status_event,
  input wire [2:0] i_wake_pin,
  // Watched outputs
  input wire [7:0] o_reg_rdata_ff,
  input wire [2:0] o_pull_up_ff,
  input wire [2:0] o_pull_down_ff,
  input wire [2:0] o_pull_auto_ff,
  input wire [2:0] o_wake_level_ff,
  input wire [2:0] o_wake_event_ff,
  input wire o_int_ff,
  input wire o_meas_en_ff,
  input wire o_bus_fs_load_ff
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Load pulse follows a taken fail-safe entry one cycle later, and only then
  chk_fs_load_pulse: assert property (i_fail_safe_entry && i_clk_en |=> o_bus_fs_load_ff)
    else $error("bus fail-safe load missing");
  chk_fs_load_cause: assert property (o_bus_fs_load_ff |-> $past(i_fail_safe_entry))
    else $error("bus fail-safe load without entry");
  // The filtered level of input c may only rise if its pin was high 4 and 8 cycles earlier
  chk_level_filtered: assert property ($rose(o_wake_level_ff[2]) |-> $past(i_wake_pin[2], 4) && $past(i_wake_pin[2], 8))
    else $error("wake level rose on a short pulse");
  // Every wake event raises the interrupt in the same cycle
  chk_int_on_wake: assert property (|o_wake_event_ff |-> o_int_ff)
    else $error("wake event without interrupt");
  chk_int_cause: assert property (o_int_ff |-> (|o_wake_event_ff) || $past(i_status_event))
    else $error("interrupt without a cause");
  // Measurement only runs in Normal Mode
  chk_meas_normal: assert property (o_meas_en_ff |-> $past(i_normal_mode))
    else $error("measurement enabled outside Normal Mode");
  // One pull choice per input at a time
  chk_pull_onehot: assert property (((o_pull_up_ff & (o_pull_down_ff | o_pull_auto_ff)) | (o_pull_down_ff & o_pull_auto_ff)) == 3'h0)
    else $error("two pull choices at once");
  // Reserved bits read as zero
  chk_src_reserved: assert property ($past(i_reg_rd && i_clk_en) && $past(i_reg_addr) == `WSC_ADDR_SRC |-> (o_reg_rdata_ff & 8'h58) == 8'h00)
    else $error("reserved source bit read as one");
  chk_cfg_reserved: assert property ($past(i_reg_rd && i_clk_en) && $past(i_reg_addr[6:1]) == 6'h04 |-> o_reg_rdata_ff[7:6] == 2'h0)
    else $error("reserved config bit read as one");
endmodule
bind wsc_top wsc_top_asserts #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) i_wsc_top_asserts (.i_clock, .i_rst, .i_clk_en,
  .i_reg_rd, .i_reg_addr, .i_normal_mode, .i_fail_safe_entry, .i_status_event, .i_wake_pin, .o_reg_rdata_ff,
  .o_pull_up_ff, .o_pull_down_ff, .o_pull_auto_ff, .o_wake_level_ff, .o_wake_event_ff, .o_int_ff, .o_meas_en_ff,
  .o_bus_fs_load_ff);

/* bench/wsc_switch_model.sv */
// Behavioural wake switches driving the three wake pins
`timescale 1ns/1ps
module wsc_switch_model (
  // Bench clock
  input wire i_clock,
  // Pin levels seen by the block
  output logic [2:0] o_pin
);
  // Switches start open, so the pins rest low
  initial o_pin = 3'h0;
  // Move one pin; changes land on the falling edge
  task automatic set_pin(input int idx, input logic lvl);
    @(negedge i_clock);
    o_pin[idx] = lvl;
  endtask
  // Closed for n cycles, then open again
  task automatic pulse(input int idx, input int n);
    set_pin(idx, 1'b1);
    repeat (n) @(negedge i_clock);
    o_pin[idx] = 1'b0;
  endtask
endmodule

/* bench/wsc_top_tb.sv */
// Self-checking bench for the wake source control block
`timescale 1ns/1ps
`include "wsc_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module wsc_top_tb;
  logic i_clock = 1'b0, i_rst = 1'b1, i_clk_en = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [6:0] i_reg_addr = 7'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_normal_mode = 1'b0, i_restart = 1'b0, i_fail_safe_entry = 1'b0, i_status_event = 1'b0;
  logic [1:0] tmr = 2'h0; // Timer on-end pulses, bit 0 timer 1
  wire [2:0] pin, pu, pd, pa, lvl, ev;
  wire [7:0] rdata;
  wire int_out, meas, fs_load;
  logic [2:0] seen = 3'h0; // Sticky record of wake events
  logic int_seen = 1'b0, load_seen = 1'b0;
  int errors = 0, comparisons = 0;
  // 25 MHz clock
  always #20 i_clock = ~i_clock;
  wsc_switch_model i_wsc_switch_model (.i_clock(i_clock), .o_pin(pin));
  // Filter counts shortened so the run stays brief
  wsc_top #(.SHORT_CYC(8), .LONG_CYC(20)) i_wsc_top (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata_ff(rdata), .i_normal_mode(i_normal_mode), .i_restart(i_restart),
    .i_fail_safe_entry(i_fail_safe_entry), .i_status_event(i_status_event), .i_timer1_on_end(tmr[0]),
    .i_timer2_on_end(tmr[1]), .i_wake_pin(pin), .o_pull_up_ff(pu), .o_pull_down_ff(pd), .o_pull_auto_ff(pa),
    .o_wake_level_ff(lvl), .o_wake_event_ff(ev), .o_int_ff(int_out), .o_meas_en_ff(meas),
    .o_bus_fs_load_ff(fs_load));
  // Collect one-cycle pulses so later checks cannot miss them
  always @(posedge i_clock) begin
    seen <= seen | ev;
    int_seen <= int_seen | int_out;
    load_seen <= load_seen | fs_load;
  end
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Register write: one strobe cycle from the next falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask
  // Register read: data stands one cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge i_clock);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clock);
    i_reg_rd = 1'b0;
    `CHK(rdata, e)
  endtask
  // Clear the records, run a pin pulse, let both edges settle
  task automatic wake_try(input int idx, input int n, input logic [2:0] e);
    @(negedge i_clock);
    seen = 3'h0;
    i_wsc_switch_model.pulse(idx, n);
    repeat (60) @(negedge i_clock);
    `CHK(seen, e)
  endtask
  // One-cycle pulse on a chip state input
  task automatic strobe(ref logic s);
    @(negedge i_clock);
    s = 1'b1;
    @(negedge i_clock);
    s = 1'b0;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge i_clock);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (3) @(negedge i_clock);
    i_rst = 1'b0;
    rd(`WSC_ADDR_SRC, 8'h07);
    rd(`WSC_ADDR_PULL, 8'h00);
    rd(`WSC_ADDR_FLT, 8'h00);
    wr(`WSC_ADDR_SRC, 8'hFF);
    wr(`WSC_ADDR_PULL, 8'hFF);
    wr(`WSC_ADDR_FLT, 8'hFF);
    wr(7'h0A, 8'hFF);
    rd(`WSC_ADDR_SRC, 8'hA7);
    rd(7'h0A, 8'h00);
    strobe(i_restart);
    rd(`WSC_ADDR_SRC, 8'hA7);
    rd(`WSC_ADDR_FLT, 8'h3F);
    wr(`WSC_ADDR_SRC, 8'h20);
    strobe(i_fail_safe_entry);
    rd(`WSC_ADDR_SRC, 8'h27);
    // Bus wake modes live in the bus control block; only its load pulse shows here
    `CHK(load_seen, 1'b1)
    wr(`WSC_ADDR_PULL, 8'h1B);
    // Pull outputs follow the register one cycle later
    @(negedge i_clock);
    `CHK({pu, pd, pa}, 9'h0A1)
    wr(`WSC_ADDR_PULL, 8'h24);
    @(negedge i_clock);
    `CHK({pu, pd, pa}, 9'h110)
    `CHK(meas, 1'b0)
    i_normal_mode = 1'b1;
    wr(`WSC_ADDR_SRC, 8'h23);
    @(negedge i_clock);
    `CHK(meas, 1'b1)
    wr(`WSC_ADDR_FLT, 8'h00);
    // Input a raises no wake event while measuring
    wake_try(0, 30, 3'h0);
    wr(`WSC_ADDR_SRC, 8'h07);
    wake_try(0, 30, 3'h1);
    wake_try(2, 4, 3'h0);
    wake_try(2, 30, 3'h4);
    wr(`WSC_ADDR_FLT, 8'h10);
    wake_try(2, 14, 3'h0);
    wake_try(2, 40, 3'h4);
    wr(`WSC_ADDR_SRC, 8'h03);
    wake_try(2, 40, 3'h0);
    // Cyclic sensing on input a, timer 1 then timer 2
    for (int k = 0; k < 2; k++) begin
      wr(`WSC_ADDR_FLT, 8'h02 + 8'(k));
      seen = 3'h0;
      i_wsc_switch_model.set_pin(0, 1'b1);
      repeat (30) @(negedge i_clock);
      // The other timer must not sample this input
      tmr = 2'(2 >> k);
      @(negedge i_clock);
      tmr = 2'h0;
      repeat (5) @(negedge i_clock);
      `CHK(seen, 3'h0)
      tmr = 2'(1 << k);
      @(negedge i_clock);
      tmr = 2'h0;
      repeat (5) @(negedge i_clock);
      `CHK(seen, 3'h1)
      `CHK(lvl[0], 1'b1)
      i_wsc_switch_model.set_pin(0, 1'b0);
      repeat (30) @(negedge i_clock);
      tmr = 2'(1 << k);
      @(negedge i_clock);
      tmr = 2'h0;
      repeat (5) @(negedge i_clock);
    end
    // Soft reset in mid-run brings back the power-on value, unlike restart
    strobe(i_rst);
    rd(`WSC_ADDR_SRC, 8'h07);
    wr(`WSC_ADDR_SRC, 8'h87);
    int_seen = 1'b0;
    strobe(i_status_event);
    repeat (3) @(negedge i_clock);
    `CHK(int_seen, 1'b1)
    wr(`WSC_ADDR_SRC, 8'h07);
    int_seen = 1'b0;
    strobe(i_status_event);
    repeat (3) @(negedge i_clock);
    `CHK(int_seen, 1'b0)
    // A write while the clock enable is low must leave the enables alone
    i_clk_en = 1'b0;
    wr(`WSC_ADDR_SRC, 8'h00);
    i_clk_en = 1'b1;
    rd(`WSC_ADDR_SRC, 8'h07);
    give_verdict();
  end
endmodule
